// >>> rtl/line_tx_pkg.sv
// Constants shared by the transmit line input port and its testbench
package line_tx_pkg;

  // Register port geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int MAX_CH     = 8;
  localparam int MARK_CNT_W = 16;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [ADDR_W-1:0] CTRL_OFFSET     = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 8'h04;
  localparam logic [ADDR_W-1:0] MARK_CNT_BASE   = 8'h10;
  localparam logic [ADDR_W-1:0] MARK_CNT_STRIDE = 8'h04;

  // Control register fields, one bit per channel from each LSB
  localparam int CTRL_ENABLE_LSB = 0;
  localparam int CTRL_DUAL_LSB   = 8;
  localparam int CTRL_INVERT_LSB = 16;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_FFFF;

  // Status register fields
  localparam int STATUS_OE_LSB    = 0;
  localparam int STATUS_HOST_BIT  = 8;
  localparam int STATUS_DRVON_BIT = 9;
  localparam int STATUS_INV_BIT   = 10;
  localparam int STATUS_TIP_LSB   = 16;
  localparam int STATUS_RING_LSB  = 24;

  // Answer for unmapped reads
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// >>> rtl/tx_line_input_port.sv
// Transmit line input port: rail sampling, driver control and register port
//
// Overview of operation
// R1: Driver-on low tri-states tip and ring
// R2: Driver-on pin also gates host-mode control
// R3: Undriven driver-on input reads as high
// R4: Default sampling on falling transmit clock edge
// R5: Negative rail sampled on same edge
// R6: Single-rail mode ignores negative rail input
// R7: Tip and ring carry bipolar line signal
// R8: Hardware clock-invert pin selects rising edge
// R9: Positive rail positive mark, negative negative
module tx_line_input_port #(
  parameter int NUM_CH = 2
) (
  input  wire logic                           SYS_CLK,             // System clock, 40 MHz
  input  wire logic                           RST_B,               // Async reset, active low
  input  wire logic [line_tx_pkg::ADDR_W-1:0] ADDR,                // Register address
  input  wire logic [line_tx_pkg::DATA_W-1:0] WDATA,               // Register write data
  input  wire logic                           WR,                  // Write strobe
  input  wire logic                           RD,                  // Read strobe
  output logic      [line_tx_pkg::DATA_W-1:0] RDATA,               // Read data, next cycle
  input  wire logic                           HOST_MODE,           // High selects host mode
  input  wire logic                           DRIVER_ON_IN,        // Driver-on pin level
  input  wire logic                           DRIVER_ON_DRIVEN,    // Pin driven from outside
  input  wire logic                           SAMPLE_EDGE_INVERT,  // Clock-invert pin
  input  wire logic [NUM_CH-1:0]              CHAN_TRANSMIT_CLOCK, // Per-channel link clock
  input  wire logic [NUM_CH-1:0]              POSITIVE_RAIL_IN,    // Positive rail data
  input  wire logic [NUM_CH-1:0]              NEGATIVE_RAIL_IN,    // Negative rail data
  output logic      [NUM_CH-1:0]              LINE_OUT_TIP,        // Tip output data
  output logic      [NUM_CH-1:0]              LINE_OUT_TIP_OE,     // Tip output enable
  output logic      [NUM_CH-1:0]              LINE_OUT_RING,       // Ring output data
  output logic      [NUM_CH-1:0]              LINE_OUT_RING_OE     // Ring output enable
);

  import line_tx_pkg::*;

  if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and MAX_CH");
  end

  // Only the bits of existing channels are writable
  localparam logic [NUM_CH-1:0] CH_ONES = {NUM_CH{1'b1}};
  localparam logic [DATA_W-1:0] CTRL_WMASK =
    (DATA_W'(CH_ONES) << CTRL_ENABLE_LSB) |
    (DATA_W'(CH_ONES) << CTRL_DUAL_LSB) |
    (DATA_W'(CH_ONES) << CTRL_INVERT_LSB);
  localparam logic [ADDR_W-1:0] CNT_END =
    ADDR_W'(int'(MARK_CNT_BASE) + NUM_CH * int'(MARK_CNT_STRIDE));

  // ---------------------------------------------------------------
  // Pin synchronisers in the system domain
  // ---------------------------------------------------------------
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;

  // Reset looks like a driven low pin, so the driver stays off until levels arrive
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta_r <= 4'h8;
      pin_sync_r <= 4'h8;
    end else begin
      pin_meta_r <= {DRIVER_ON_DRIVEN, SAMPLE_EDGE_INVERT, DRIVER_ON_IN, HOST_MODE};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire host_mode  = pin_sync_r[0];
  wire drvon_lvl  = pin_sync_r[1];
  wire inv_pin    = pin_sync_r[2];
  wire drvon_seen = pin_sync_r[3];
  // Pull-up applied after the synchroniser: an undriven pin counts as high
  wire drvon      = drvon_seen ? drvon_lvl : 1'b1; // see R3

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rdata_r;

  wire               ctrl_hit   = (ADDR == CTRL_OFFSET);
  wire               status_hit = (ADDR == STATUS_OFFSET);
  wire               cnt_range  = (ADDR >= MARK_CNT_BASE) && (ADDR < CNT_END);
  wire               cnt_hit    = cnt_range && (ADDR[1:0] == 2'h0);
  wire [ADDR_W-1:0]  cnt_off    = ADDR - MARK_CNT_BASE;
  wire [ADDR_W-3:0]  cnt_sel    = cnt_off[ADDR_W-1:2];
  wire               ctrl_wr    = WR && ctrl_hit;
  wire               cnt_wr     = WR && cnt_hit;

  wire [NUM_CH-1:0]  ctl_enable = ctrl_r[CTRL_ENABLE_LSB +: NUM_CH];
  wire [NUM_CH-1:0]  ctl_dual   = ctrl_r[CTRL_DUAL_LSB +: NUM_CH];
  wire [NUM_CH-1:0]  ctl_invert = ctrl_r[CTRL_INVERT_LSB +: NUM_CH];

  wire [DATA_W-1:0]  ctrl_nxt   = ctrl_wr ? (WDATA & CTRL_WMASK) : ctrl_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= CTRL_RESET & CTRL_WMASK;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel selection of edge, rail format and driver enable
  // ---------------------------------------------------------------
  // Host mode takes the edge from the register, hardware mode from the pin
  wire [NUM_CH-1:0] edge_inv_eff = host_mode ? ctl_invert : {NUM_CH{inv_pin}}; // see R8
  // The pin gates the driver in both modes; software only narrows it
  wire [NUM_CH-1:0] sw_enable    = host_mode ? ctl_enable : CH_ONES; // see R2
  wire [NUM_CH-1:0] oe_nxt       = {NUM_CH{drvon}} & sw_enable;      // see R1

  logic [NUM_CH-1:0] oe_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      oe_r <= '0;
    end else begin
      oe_r <= oe_nxt; // see R1
    end
  end

  // Registered so the link-side synchronisers never see a mux glitch
  logic [NUM_CH-1:0] inv_cfg_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      inv_cfg_r <= '0;
    end else begin
      inv_cfg_r <= edge_inv_eff; // see R8
    end
  end

  // ---------------------------------------------------------------
  // Channel slices on their own link clocks
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] tip_link;
  logic [NUM_CH-1:0] ring_link;
  logic [NUM_CH-1:0] mark_tgl_link;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    tx_rail_channel u_chan (
      .chan_transmit_clock (CHAN_TRANSMIT_CLOCK[ch]),
      .rst_b               (RST_B),
      .dual_rail           (ctl_dual[ch]),
      .edge_invert         (inv_cfg_r[ch]),
      .positive_rail_in    (POSITIVE_RAIL_IN[ch]),
      .negative_rail_in    (NEGATIVE_RAIL_IN[ch]),
      .line_out_tip        (tip_link[ch]),
      .line_out_ring       (ring_link[ch]),
      .mark_toggle         (mark_tgl_link[ch])
    );
  end

  // ---------------------------------------------------------------
  // Line state and mark events into the system domain
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] tip_meta_r;
  logic [NUM_CH-1:0] tip_sync_r;
  logic [NUM_CH-1:0] ring_meta_r;
  logic [NUM_CH-1:0] ring_sync_r;
  logic [NUM_CH-1:0] tgl_meta_r;
  logic [NUM_CH-1:0] tgl_sync_r;
  logic [NUM_CH-1:0] tgl_prev_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tip_meta_r  <= '0;
      tip_sync_r  <= '0;
      ring_meta_r <= '0;
      ring_sync_r <= '0;
      tgl_meta_r  <= '0;
      tgl_sync_r  <= '0;
      tgl_prev_r  <= '0;
    end else begin
      tip_meta_r  <= tip_link;
      tip_sync_r  <= tip_meta_r;
      ring_meta_r <= ring_link;
      ring_sync_r <= ring_meta_r;
      tgl_meta_r  <= mark_tgl_link;
      tgl_sync_r  <= tgl_meta_r;
      tgl_prev_r  <= tgl_sync_r;
    end
  end

  // Faster than the link clock, so each toggle is seen at least once
  wire [NUM_CH-1:0] mark_evt = tgl_sync_r ^ tgl_prev_r;

  // ---------------------------------------------------------------
  // Mark counters: saturate, cleared by any write to their word
  // ---------------------------------------------------------------
  logic [MARK_CNT_W-1:0] mark_cnt_r   [NUM_CH];
  logic [MARK_CNT_W-1:0] mark_cnt_nxt [NUM_CH];

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      mark_cnt_nxt[i] = mark_cnt_r[i];
      // A mark arriving with the clear is kept
      if (cnt_wr && (int'(cnt_sel) == i)) begin
        mark_cnt_nxt[i] = MARK_CNT_W'(mark_evt[i]);
      end else if (mark_evt[i] && (mark_cnt_r[i] != {MARK_CNT_W{1'b1}})) begin
        mark_cnt_nxt[i] = mark_cnt_r[i] + MARK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mark_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        mark_cnt_r[i] <= mark_cnt_nxt[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] cnt_word;

  always_comb begin
    status_word                               = '0;
    status_word[STATUS_OE_LSB +: NUM_CH]      = oe_r;
    status_word[STATUS_HOST_BIT]              = host_mode;
    status_word[STATUS_DRVON_BIT]             = drvon;
    status_word[STATUS_INV_BIT]               = inv_pin;
    status_word[STATUS_TIP_LSB +: NUM_CH]     = tip_sync_r;
    status_word[STATUS_RING_LSB +: NUM_CH]    = ring_sync_r;
  end

  always_comb begin
    cnt_word = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (int'(cnt_sel) == i) begin
        cnt_word = DATA_W'(mark_cnt_r[i]);
      end
    end
  end

  wire [DATA_W-1:0] rd_word =
    ctrl_hit   ? ctrl_r :
    status_hit ? status_word :
    cnt_hit    ? cnt_word : UNMAPPED_DATA;

  // Data stand for exactly one cycle after the read strobe
  wire [DATA_W-1:0] rdata_nxt = RD ? rd_word : '0;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RDATA            = rdata_r;
  assign LINE_OUT_TIP     = tip_link;  // see R7
  assign LINE_OUT_RING    = ring_link; // see R7
  assign LINE_OUT_TIP_OE  = oe_r;      // see R1
  assign LINE_OUT_RING_OE = oe_r;      // see R1

endmodule // tx_line_input_port

// >>> rtl/tx_rail_channel.sv
// One transmit channel: rail sampling on the link clock and bipolar encoding
module tx_rail_channel (
  input  wire logic chan_transmit_clock, // Link clock from terminal equipment
  input  wire logic rst_b,               // Async reset, active low
  input  wire logic dual_rail,           // Level from system domain
  input  wire logic edge_invert,         // Level from system domain
  input  wire logic positive_rail_in,    // Positive rail data
  input  wire logic negative_rail_in,    // Negative rail data
  output logic      line_out_tip,        // Positive mark pulse
  output logic      line_out_ring,       // Negative mark pulse
  output logic      mark_toggle          // Flips once per mark sent
);

  logic       rst_meta_r;
  logic       rst_sync_r;
  logic [1:0] cfg_meta_r;
  logic [1:0] cfg_sync_r;
  logic       pos_rise_r;
  logic       neg_rise_r;
  logic       pos_fall_r;
  logic       neg_fall_r;
  logic       polarity_r;
  logic       tip_r;
  logic       ring_r;
  logic       toggle_r;

  // Release of reset synchronised to the link clock
  always_ff @(posedge chan_transmit_clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge chan_transmit_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_meta_r <= 2'h0;
      cfg_sync_r <= 2'h0;
    end else begin
      cfg_meta_r <= {edge_invert, dual_rail};
      cfg_sync_r <= cfg_meta_r;
    end
  end

  // Both edges always capture; the selection below picks one
  always_ff @(posedge chan_transmit_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pos_rise_r <= 1'b0;
      neg_rise_r <= 1'b0;
    end else begin
      pos_rise_r <= positive_rail_in; // see R8
      neg_rise_r <= negative_rail_in; // see R5
    end
  end

  always_ff @(negedge chan_transmit_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pos_fall_r <= 1'b0;
      neg_fall_r <= 1'b0;
    end else begin
      pos_fall_r <= positive_rail_in; // see R4
      neg_fall_r <= negative_rail_in; // see R5
    end
  end

  wire dual_sel = cfg_sync_r[0];
  wire inv_sel  = cfg_sync_r[1];
  wire pos_smp  = inv_sel ? pos_rise_r : pos_fall_r; // see R4
  wire neg_smp  = inv_sel ? neg_rise_r : neg_fall_r; // see R5
  // Both rails high is an illegal code; sent as a space
  wire dual_tip  = pos_smp & ~neg_smp; // see R9
  wire dual_ring = neg_smp & ~pos_smp; // see R9
  // Single rail: negative rail unused, marks alternate in polarity
  wire tip_nxt  = dual_sel ? dual_tip : (pos_smp & ~polarity_r); // see R6
  wire ring_nxt = dual_sel ? dual_ring : (pos_smp & polarity_r); // see R6
  wire pol_nxt  = dual_sel ? 1'b0 : (polarity_r ^ pos_smp);
  wire tgl_nxt  = toggle_r ^ (tip_nxt | ring_nxt);

  always_ff @(posedge chan_transmit_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      polarity_r <= 1'b0;
      tip_r      <= 1'b0;
      ring_r     <= 1'b0;
      toggle_r   <= 1'b0;
    end else begin
      polarity_r <= pol_nxt;
      tip_r      <= tip_nxt;  // see R7
      ring_r     <= ring_nxt; // see R7
      toggle_r   <= tgl_nxt;
    end
  end

  assign line_out_tip  = tip_r;
  assign line_out_ring = ring_r;
  assign mark_toggle   = toggle_r;

endmodule // tx_rail_channel

// >>> test/tx_framer_model.sv
// Terminal equipment model for one channel's rail data
module tx_framer_model (
  input  wire logic clk,            // Transmit clock
  input  wire logic launch_fall,    // Launch on falling edge
  input  wire logic ground_neg,     // Hold negative rail low
  input  wire logic next_pos,       // Next positive bit
  input  wire logic next_neg,       // Next negative bit
  output logic      pos_out = 1'b0, // Positive rail
  output logic      neg_out = 1'b0  // Negative rail
);
  timeunit 1ns;
  timeprecision 1ps;
  // Launch opposite the sampling edge so setup is half a period
  always @(clk) begin
    if (clk ^ launch_fall) begin
      pos_out <= next_pos;
      neg_out <= next_neg & ~ground_neg;
    end
  end
endmodule // tx_framer_model

// >>> test/tx_line_input_port_tb_top.sv
// Self-checking bench for the transmit line input port
module tx_line_input_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import line_tx_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst_b   = 1'b0;
  logic [ADDR_W-1:0] addr    = 8'h00;
  logic [DATA_W-1:0] wdata   = 32'h0000_0000;
  logic [DATA_W-1:0] rdata, got;
  logic              wr = 1'b0, rd = 1'b0, host = 1'b0, inv_pin = 1'b0;
  logic              drv_on = 1'b1, drv_drv = 1'b1;
  logic [1:0]        lclk = 2'h0, fall = 2'h0, gnd = 2'h0, par = 2'h0;
  logic [1:0]        nxt_p = 2'h0, nxt_n = 2'h0;
  logic [1:0]        pos, neg, tip, ring, tip_oe, ring_oe;
  int                bad_count = 0;
  int                check_count = 0;

  always #12.5 sys_clk = ~sys_clk;
  always #15 lclk[0] = ~lclk[0];
  initial #7.3 forever #15 lclk[1] = ~lclk[1];

  tx_line_input_port #(.NUM_CH(2)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .HOST_MODE(host), .DRIVER_ON_IN(drv_on), .DRIVER_ON_DRIVEN(drv_drv),
    .SAMPLE_EDGE_INVERT(inv_pin), .CHAN_TRANSMIT_CLOCK(lclk), .POSITIVE_RAIL_IN(pos),
    .NEGATIVE_RAIL_IN(neg), .LINE_OUT_TIP(tip), .LINE_OUT_TIP_OE(tip_oe),
    .LINE_OUT_RING(ring), .LINE_OUT_RING_OE(ring_oe));

  for (genvar c = 0; c < 2; c++) begin : g_fr
    tx_framer_model fr (.clk(lclk[c]), .launch_fall(fall[c]), .ground_neg(gnd[c]),
      .next_pos(nxt_p[c]), .next_neg(nxt_n[c]), .pos_out(pos[c]), .neg_out(neg[c]));
  end

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic sys_wait;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // Config crosses into the link domain; rails are idle meanwhile
  task automatic settle;
    repeat (12) @(posedge lclk[0]);
  endtask

  // Eight bits on one channel, judged a fixed number of periods later
  task automatic stream(input int c, input logic [7:0] p, n, input logic single);
    logic [1:0] e [10];
    int lat;
    lat = fall[c] ? 2 : 1;
    for (int i = 0; i < 8; i++) begin
      if (!single) e[i] = {p[i] & ~n[i], n[i] & ~p[i]};
      else if (p[i]) begin
        e[i] = {~par[c], par[c]};
        par[c] = ~par[c];
      end else e[i] = 2'h0;
    end
    @(negedge lclk[c]);
    for (int i = 0; i < 8 + lat; i++) begin
      if (fall[c]) @(posedge lclk[c]);
      nxt_p[c] = (i < 8) ? p[i%8] : 1'b0;
      nxt_n[c] = (i < 8) ? n[i%8] : 1'b0;
      @(negedge lclk[c]);
      if (i >= lat) check({tip[c], ring[c]}, e[i-lat]);
    end
  endtask

  task automatic t_pins;
    sys_wait();
    check({tip_oe, ring_oe}, 4'hF);
    @(posedge sys_clk) drv_on <= 1'b0;
    sys_wait();
    check({tip_oe, ring_oe}, 4'h0);
    @(posedge sys_clk) drv_drv <= 1'b0;
    sys_wait();
    check({tip_oe, ring_oe}, 4'hF);
    @(posedge sys_clk) drv_drv <= 1'b1;
    drv_on <= 1'b1;
  endtask

  task automatic t_host;
    @(posedge sys_clk) host <= 1'b1;
    reg_wr(CTRL_OFFSET, 32'h0000_0302);
    reg_wr(8'h08, 32'hFFFF_FFFF);
    reg_rd(CTRL_OFFSET);
    check(got, 32'h0000_0302);
    reg_rd(8'h08);
    check(got, 32'h0000_0000);
    sys_wait();
    check({tip_oe, ring_oe}, 4'hA);
    @(posedge sys_clk) drv_on <= 1'b0;
    sys_wait();
    check({tip_oe, ring_oe}, 4'h0);
    @(posedge sys_clk) drv_on <= 1'b1;
    reg_wr(CTRL_OFFSET, 32'h0000_0303);
    host <= 1'b0;
  endtask

  // Partner grounds the unused negative rail; its data bits are dropped
  task automatic t_single;
    reg_wr(CTRL_OFFSET, 32'h0000_0003);
    gnd = 2'h3;
    settle();
    stream(0, 8'hB5, 8'hFF, 1'b1);
    stream(1, 8'h6D, 8'hFF, 1'b1);
    gnd = 2'h0;
  endtask

  task automatic t_dual;
    reg_wr(CTRL_OFFSET, 32'h0000_0303);
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk) inv_pin <= v[0];
      fall = {v[0], v[0]};
      settle();
      stream(0, 8'hCA, 8'hA6, 1'b0);
      stream(1, 8'hCA, 8'hA6, 1'b0);
    end
  endtask

  // Pin stays high in host mode, where only the control bit counts
  task automatic t_host_inv;
    @(posedge sys_clk) host <= 1'b1;
    reg_wr(CTRL_OFFSET, 32'h0001_0303);
    fall = 2'h1;
    settle();
    stream(0, 8'h5A, 8'h3C, 1'b0);
    stream(1, 8'h5A, 8'h3C, 1'b0);
  endtask

  // Ch0 count cleared while idle, then one dual-rail burst of four marks
  task automatic t_counts;
    reg_wr(MARK_CNT_BASE, 32'h0000_0000);
    stream(0, 8'hCA, 8'hA6, 1'b0);
    sys_wait();
    reg_rd(MARK_CNT_BASE);
    check(got, 32'h0000_0004);
    reg_rd(STATUS_OFFSET);
    check(got, 32'h0000_0703);
  endtask

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    check({tip_oe, ring_oe}, 4'h0);
    rst_b <= 1'b1;
    t_pins();
    t_host();
    t_single();
    t_dual();
    t_host_inv();
    t_counts();
    complete_run();
  end
endmodule // tx_line_input_port_tb_top

// >>> test/tx_port_monitor.sv
// Pin-level checks for the transmit line input port
module tx_port_monitor #(
  parameter int NUM_CH = 2
) (
  input wire logic              SYS_CLK,             // System clock
  input wire logic              RST_B,               // Reset, low
  input wire logic              HOST_MODE,           // Mode pin
  input wire logic              DRIVER_ON_IN,        // Driver-on pin
  input wire logic              DRIVER_ON_DRIVEN,    // Pin driven
  input wire logic [NUM_CH-1:0] CHAN_TRANSMIT_CLOCK, // Link clocks
  input wire logic [NUM_CH-1:0] POSITIVE_RAIL_IN,    // Positive rail
  input wire logic [NUM_CH-1:0] NEGATIVE_RAIL_IN,    // Negative rail
  input wire logic [NUM_CH-1:0] LINE_OUT_TIP,        // Tip data
  input wire logic [NUM_CH-1:0] LINE_OUT_RING,       // Ring data
  input wire logic [NUM_CH-1:0] LINE_OUT_TIP_OE,     // Tip enable
  input wire logic [NUM_CH-1:0] LINE_OUT_RING_OE     // Ring enable
);
  timeunit 1ns;
  timeprecision 1ps;
  a_oe_pins_match: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    LINE_OUT_TIP_OE == LINE_OUT_RING_OE) else $error("enables differ");
  a_driver_off_hw: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!HOST_MODE && DRIVER_ON_DRIVEN && !DRIVER_ON_IN)[*4] |=> LINE_OUT_TIP_OE == '0)
    else $error("driver on with pin low");
  a_driver_on_hw: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!HOST_MODE && DRIVER_ON_DRIVEN && DRIVER_ON_IN)[*5] |=> LINE_OUT_TIP_OE == '1)
    else $error("driver off with pin high");
  a_pullup_enables: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!HOST_MODE && !DRIVER_ON_DRIVEN)[*5] |=> LINE_OUT_RING_OE == '1)
    else $error("open pin left driver off");
  a_host_driver_off: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HOST_MODE && DRIVER_ON_DRIVEN && !DRIVER_ON_IN)[*4] |=> LINE_OUT_RING_OE == '0)
    else $error("host mode ignored pin");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_tip_needs_pos: assert property (@(negedge CHAN_TRANSMIT_CLOCK[i])
      disable iff (!RST_B) LINE_OUT_TIP[i] |-> $past(POSITIVE_RAIL_IN[i]))
      else $error("tip without positive rail");
    a_space_on_zero: assert property (@(negedge CHAN_TRANSMIT_CLOCK[i])
      disable iff (!RST_B) !$past(POSITIVE_RAIL_IN[i] | NEGATIVE_RAIL_IN[i])
      |-> !(LINE_OUT_TIP[i] | LINE_OUT_RING[i])) else $error("mark for a space");
    a_marks_exclusive: assert property (@(posedge CHAN_TRANSMIT_CLOCK[i])
      disable iff (!RST_B) !(LINE_OUT_TIP[i] && LINE_OUT_RING[i]))
      else $error("both marks at once");
  end
endmodule // tx_port_monitor

bind tx_line_input_port tx_port_monitor #(.NUM_CH(NUM_CH)) mon (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .HOST_MODE(HOST_MODE),
  .DRIVER_ON_IN(DRIVER_ON_IN), .DRIVER_ON_DRIVEN(DRIVER_ON_DRIVEN),
  .CHAN_TRANSMIT_CLOCK(CHAN_TRANSMIT_CLOCK), .POSITIVE_RAIL_IN(POSITIVE_RAIL_IN),
  .NEGATIVE_RAIL_IN(NEGATIVE_RAIL_IN), .LINE_OUT_TIP(LINE_OUT_TIP),
  .LINE_OUT_RING(LINE_OUT_RING), .LINE_OUT_TIP_OE(LINE_OUT_TIP_OE),
  .LINE_OUT_RING_OE(LINE_OUT_RING_OE));
